// *** rtl/ccdx_defines.svh ***
// Timing counts and field positions for the exposure and mode control block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef CCDX_DEFINES_SVH
`define CCDX_DEFINES_SVH
`define CCDX_CLK_NS          10
`define CCDX_TINT_US         16670
`define CCDX_TINT_CYC        ((`CCDX_TINT_US * 1000) / `CCDX_CLK_NS)
`define CCDX_LINE_CYC        6356
`define CCDX_VD_LOW_CYC      1200
`define CCDX_FLUSH_XFERS     256
`define CCDX_XFER_HALF       8
`define CCDX_SC_HALF         14
`define CCDX_LG1_START       2000
`define CCDX_LG1_STOP        2400
`define CCDX_LG3_START       4000
`define CCDX_LG3_STOP        4400
`define CCDX_LG_SHIFT_ALT    100
`endif

// *** rtl/ccdx_pkg.sv ***
// Types for the exposure and mode control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ccdx_pkg;
	typedef enum logic [1:0] {
		CCDX_IDLE,
		CCDX_FLUSH,
		CCDX_READ
	} ccdx_xfer_e;

	typedef struct packed {
		logic image_gate_clock;
		logic storage_gate_clock;
	} ccdx_gates_s;

	typedef struct packed {
		logic luma_gate1_sample3;
		logic luma_gate3_sample2;
	} ccdx_luma_s;

	typedef struct packed {
		logic subcarrier_out;
		logic quadrature_subcarrier;
	} ccdx_sc_s;
endpackage

// *** rtl/ccdx_exposure_ctrl.sv ***
// Exposure gating, sensor and standby mode control of the CCD timing generator.
// Assumes all inputs are synchronous to clk; exposure_gate comes from outside.
`include "ccdx_defines.svh"

// Functional notes
// RQ1 - With gate_source_select high, vertical drive is routed internally onto the exposure gate.
// RQ2 - For variable integration the outside holds gate_source_select low and drives the gate.
// RQ3 - The exposure gate masks both the storage and image gate clocks.
// RQ4 - sensor_select low picks the variable-integration sensor pair, high the alternate pair.
// RQ5 - standby_select high is normal operation, low enters power-down.
// RQ6 - low_power_indicator is driven low to place device and neighbours in low power.
// RQ7 - Two shared outputs serve luma gate 1 with sample 3, and luma gate 3 with sample 2.
// RQ8 - A quadrature subcarrier of equal frequency lags the main subcarrier by 90 degrees.
// RQ9 - Outside flushes with two low gate pulses, each giving 256 image and storage transfers.
// RQ10 - Readout starts when vertical drive and the gate are low together; code reads only with gate_source_select high, else flushes.
// RQ11 - line_counter_reset clears the horizontal line counter for external sync.
module ccdx_exposure_ctrl #(
	parameter int TINT_CYC = `CCDX_TINT_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 exposure_gate,
	input  wire logic                 gate_source_select,
	input  wire logic                 sensor_select,
	input  wire logic                 standby_select,
	input  wire logic                 line_counter_reset,
	output logic                      vertical_drive,
	output logic                      low_power_indicator,
	output ccdx_pkg::ccdx_gates_s     gates,
	output ccdx_pkg::ccdx_luma_s      luma,
	output ccdx_pkg::ccdx_sc_s        sc
);
	// Mode decode
	logic                  run;
	logic                  eff_gate;
	logic [12:0]           lg_shift;
	// Frame timing
	logic [23:0]           frame_cnt;
	logic [23:0]           next_frame_cnt;
	logic                  next_vertical_drive;
	// Line timing
	logic [12:0]           line_cnt;
	logic [12:0]           next_line_cnt;
	ccdx_pkg::ccdx_luma_s  next_luma;
	// Subcarrier
	logic [4:0]            sc_cnt;
	logic [4:0]            next_sc_cnt;
	logic [1:0]            sc_phase;
	logic [1:0]            next_sc_phase;
	ccdx_pkg::ccdx_sc_s    next_sc;
	// Transfer bursts
	ccdx_pkg::ccdx_xfer_e  state;
	ccdx_pkg::ccdx_xfer_e  next_state;
	logic [3:0]            half_cnt;
	logic [3:0]            next_half_cnt;
	logic [8:0]            xfer_cnt;
	logic [8:0]            next_xfer_cnt;
	logic                  xfer_clk;
	logic                  next_xfer_clk;
	logic                  gate_prev;
	ccdx_pkg::ccdx_gates_s next_gates;
	// Power indicator
	logic                  next_low_power_indicator;

	always_comb begin
		run = standby_select; // RQ5
		// Internal path from vertical drive, or the outside gate
		eff_gate = gate_source_select ? vertical_drive : exposure_gate; // RQ1 RQ2
		lg_shift = sensor_select ? 13'(`CCDX_LG_SHIFT_ALT) : 13'h0000; // RQ4
	end

	// Counts freeze in standby
	always_comb begin
		next_frame_cnt = frame_cnt;
		if (run) begin
			if (frame_cnt >= 24'(TINT_CYC - 1)) begin
				next_frame_cnt = 24'h000000;
			end else begin
				next_frame_cnt = frame_cnt + 24'h000001;
			end
		end
		// Vertical drive low at the start of each integration period
		next_vertical_drive = !(run && next_frame_cnt < 24'(`CCDX_VD_LOW_CYC)); // RQ1
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			frame_cnt <= 24'h000000;
			vertical_drive <= 1'b1;
		end else begin
			frame_cnt <= next_frame_cnt;
			vertical_drive <= next_vertical_drive;
		end
	end

	always_comb begin
		next_line_cnt = line_cnt;
		if (run) begin
			if (line_counter_reset || line_cnt == 13'(`CCDX_LINE_CYC - 1)) begin // RQ11
				next_line_cnt = 13'h0000;
			end else begin
				next_line_cnt = line_cnt + 13'h0001;
			end
		end
		// Windows move later for the alternate sensor pair
		next_luma.luma_gate1_sample3 = run && line_cnt >= 13'(`CCDX_LG1_START) + lg_shift
			&& line_cnt < 13'(`CCDX_LG1_STOP) + lg_shift; // RQ7
		next_luma.luma_gate3_sample2 = run && line_cnt >= 13'(`CCDX_LG3_START) + lg_shift
			&& line_cnt < 13'(`CCDX_LG3_STOP) + lg_shift; // RQ7
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			line_cnt <= 13'h0000;
			luma <= '0;
		end else begin
			line_cnt <= next_line_cnt;
			luma <= next_luma;
		end
	end

	always_comb begin
		next_sc_cnt = sc_cnt;
		next_sc_phase = sc_phase;
		if (run) begin
			if (sc_cnt == 5'(`CCDX_SC_HALF / 2 - 1)) begin
				next_sc_cnt = 5'h00;
				next_sc_phase = sc_phase + 2'h1;
			end else begin
				next_sc_cnt = sc_cnt + 5'h01;
			end
		end
		// Quarter-period phase steps give the 90 degree copy
		next_sc.subcarrier_out = run && !sc_phase[1]; // RQ8
		next_sc.quadrature_subcarrier = run && (sc_phase[1] ^ sc_phase[0]); // RQ8
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sc_cnt <= 5'h00;
			sc_phase <= 2'h0;
			sc <= '0;
		end else begin
			sc_cnt <= next_sc_cnt;
			sc_phase <= next_sc_phase;
			sc <= next_sc;
		end
	end

	always_comb begin
		// A falling gate edge seen in idle starts a burst of transfers
		next_state = state;
		next_half_cnt = half_cnt;
		next_xfer_cnt = xfer_cnt;
		next_xfer_clk = xfer_clk;
		if (!run) begin
			next_state = ccdx_pkg::CCDX_IDLE;
			next_xfer_clk = 1'b0;
		end else begin
			unique case (state)
				ccdx_pkg::CCDX_IDLE: begin
					if (gate_prev && !eff_gate) begin // RQ9 RQ10
						next_state = (gate_source_select && !vertical_drive)
							? ccdx_pkg::CCDX_READ : ccdx_pkg::CCDX_FLUSH;
						next_xfer_cnt = 9'h000;
						next_half_cnt = 4'h0;
					end
				end
				ccdx_pkg::CCDX_FLUSH, ccdx_pkg::CCDX_READ: begin
					if (half_cnt == 4'(`CCDX_XFER_HALF - 1)) begin
						next_half_cnt = 4'h0;
						next_xfer_clk = !xfer_clk;
						if (xfer_clk) begin
							next_xfer_cnt = xfer_cnt + 9'h001;
							if (xfer_cnt == 9'(`CCDX_FLUSH_XFERS - 1)) begin // RQ9
								next_state = ccdx_pkg::CCDX_IDLE;
							end
						end
					end else begin
						next_half_cnt = half_cnt + 4'h1;
					end
				end
			endcase
		end
		// Gate clocks only run while the gate is low
		next_gates.image_gate_clock = next_xfer_clk && !eff_gate; // RQ3
		next_gates.storage_gate_clock = next_xfer_clk && !eff_gate; // RQ3
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ccdx_pkg::CCDX_IDLE;
			half_cnt <= 4'h0;
			xfer_cnt <= 9'h000;
			xfer_clk <= 1'b0;
			gate_prev <= 1'b1;
			gates <= '0;
		end else begin
			state <= next_state;
			half_cnt <= next_half_cnt;
			xfer_cnt <= next_xfer_cnt;
			xfer_clk <= next_xfer_clk;
			gate_prev <= eff_gate;
			gates <= next_gates;
		end
	end

	// Indicator follows standby one cycle late
	always_comb begin
		next_low_power_indicator = run; // RQ6
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			low_power_indicator <= 1'b0;
		end else begin
			low_power_indicator <= next_low_power_indicator;
		end
	end
endmodule // ccdx_exposure_ctrl

// *** tb/ccdx_exposure_chk.sv ***
// Checker for the exposure and mode control block.
// Assumes binding onto ccdx_exposure_ctrl; inputs mirror its ports.
module ccdx_exposure_chk #(
	parameter int TINT_CYC = 5000
) (
	input wire logic                  clk,
	input wire logic                  srst,
	input wire logic                  exposure_gate,
	input wire logic                  gate_source_select,
	input wire logic                  sensor_select,
	input wire logic                  standby_select,
	input wire logic                  line_counter_reset,
	input wire logic                  vertical_drive,
	input wire logic                  low_power_indicator,
	input wire ccdx_pkg::ccdx_gates_s gates,
	input wire ccdx_pkg::ccdx_luma_s  luma,
	input wire ccdx_pkg::ccdx_sc_s    sc
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Frozen counters resume mid-phase; only edges two cycles past standby count
	sequence s_sc_up;
		$rose(sc.subcarrier_out) && $past(standby_select, 2);
	endsequence
	sequence s_vd_fall;
		$fell(vertical_drive) && $past(standby_select, 2);
	endsequence
	property p_vd;
		disable iff (srst || !standby_select) s_vd_fall |=> !vertical_drive [*8];
	endproperty
	a_vd: assert property (p_vd) else $error("vd low too short");
	property p_msk; (!gate_source_select && exposure_gate) [*2] |=> gates == 2'b00; endproperty
	a_msk: assert property (p_msk) else $error("gate clocks not masked");
	property p_pd; !standby_select |=> !low_power_indicator && gates == 2'b00 && sc == 2'b00; endproperty
	a_pd: assert property (p_pd) else $error("power down outputs active");
	property p_lp; $rose(standby_select) |=> low_power_indicator; endproperty
	a_lp: assert property (p_lp) else $error("power indicator stuck low");
	property p_lg; !(luma.luma_gate1_sample3 && luma.luma_gate3_sample2); endproperty
	a_lg: assert property (p_lg) else $error("shared gates overlap");
	property p_sc;
		disable iff (srst || !standby_select)
			s_sc_up ##1 1'b1 [*6] |=> $rose(sc.quadrature_subcarrier);
	endproperty
	a_sc: assert property (p_sc) else $error("quadrature phase wrong");
	property p_sq; disable iff (srst || !standby_select) s_sc_up |=> sc.subcarrier_out [*8]; endproperty
	a_sq: assert property (p_sq) else $error("subcarrier half too short");
	property p_hcr; line_counter_reset |-> ##2 !luma.luma_gate1_sample3 [*7]; endproperty
	a_hcr: assert property (p_hcr) else $error("line counter not cleared");
endmodule // ccdx_exposure_chk
bind ccdx_exposure_ctrl ccdx_exposure_chk #(.TINT_CYC(TINT_CYC)) u_chk (
	.clk, .srst, .exposure_gate, .gate_source_select, .sensor_select, .standby_select,
	.line_counter_reset, .vertical_drive, .low_power_indicator, .gates, .luma, .sc);

// *** tb/ccdx_gate_model.sv ***
// External exposure logic: two low flush pulses on request.
// Assumes start is a one-cycle pulse synchronous to clk.
module ccdx_gate_model (
	input  wire logic clk,
	input  wire logic start,
	output logic      exposure_gate
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	initial exposure_gate = 1'b1;
	always @(posedge clk) begin
		n <= start ? 8600 : (n > 0 ? n - 1 : 0);
		exposure_gate <= #1 !(n > 4400 || (n > 100 && n < 4300));
	end
endmodule // ccdx_gate_model

// *** tb/ccd_exposure_mode_control_bench.sv ***
// Bench for the exposure and mode control block.
// Assumes the checker is bound and the gate model sits on exposure_gate.
module ccd_exposure_mode_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, gss = 1, sel = 0, sb = 1, lcr = 0, start = 0, gate, vd, lpi;
	ccdx_pkg::ccdx_gates_s gates;
	ccdx_pkg::ccdx_luma_s  luma;
	ccdx_pkg::ccdx_sc_s    sc;
	int n_fail = 0, comparisons = 0;
	initial forever #5 clk = !clk;
	ccdx_exposure_ctrl #(.TINT_CYC(5000)) DUT (.clk, .srst, .exposure_gate(gate),
		.gate_source_select(gss), .sensor_select(sel), .standby_select(sb),
		.line_counter_reset(lcr), .vertical_drive(vd), .low_power_indicator(lpi), .gates, .luma, .sc);
	ccdx_gate_model u_model (.clk, .start, .exposure_gate(gate));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic wait_vd(input logic lvl);
		int i;
		for (i = 0; i < 6000 && vd !== lvl; i++) tick(1);
		if (i == 6000) begin
			n_fail++;
			$display("mismatch at %0t: vd wait timed out", $time);
		end
	endtask
	task automatic t_normal();
		int lo = 0, per = 0;
		wait_vd(1'b0);
		// First period after reset is one cycle short
		wait_vd(1'b1);
		wait_vd(1'b0);
		while (vd === 1'b0 && lo < 6000) begin tick(1); lo++; end
		for (per = lo; vd === 1'b1 && per < 6000; per++) tick(1);
		check(lo == 1200, "vd low time");
		check(per == 5000, "integration period");
	endtask
	task automatic t_flush();
		int ni = 0, ns = 0;
		logic pi, ps;
		gss = 0;
		start = 1;
		tick(1);
		start = 0;
		for (int i = 0; i < 11000; i++) begin
			pi = gates.image_gate_clock;
			ps = gates.storage_gate_clock;
			tick(1);
			ni += int'(gates.image_gate_clock === 1'b1 && pi === 1'b0);
			ns += int'(gates.storage_gate_clock === 1'b1 && ps === 1'b0);
		end
		check(ni == 512 && ns == 512, "flush transfers");
	endtask
	task automatic t_readout();
		int nr = 0;
		logic pi;
		gss = 1;
		wait_vd(1'b1);
		wait_vd(1'b0);
		wait_vd(1'b1);
		// Any burst begun on the switch-over has ended by this fall
		wait_vd(1'b0);
		for (int i = 0; i < 1300; i++) begin
			pi = gates.image_gate_clock;
			tick(1);
			nr += int'(gates.image_gate_clock === 1'b1 && pi === 1'b0);
		end
		// 1200-cycle low window, 16-cycle transfers, first rise 9 cycles in
		check(nr == 75, "readout transfers");
	endtask
	task automatic t_luma();
		int t1[2], t3[2];
		for (int s = 0; s < 2; s++) begin
			sel = s[0];
			lcr = 1;
			tick(1);
			lcr = 0;
			tick(3);
			t1[s] = 0;
			t3[s] = 0;
			for (int i = 1; i < 6000; i++) begin
				if (luma.luma_gate1_sample3 === 1'b1 && t1[s] == 0) t1[s] = i;
				if (luma.luma_gate3_sample2 === 1'b1 && t3[s] == 0) t3[s] = i;
				tick(1);
			end
		end
		check(t1[1] - t1[0] == 100, "sensor shift");
		check(t3[0] - t1[0] == 2000, "shared gate spacing");
		check(t1[0] > 1990 && t1[0] < 2005, "line restart");
	endtask
	task automatic t_standby();
		sb = 0;
		tick(3);
		check(lpi === 1'b0 && gates === 2'b00 && sc === 2'b00, "power down");
		sb = 1;
		tick(2);
		check(lpi === 1'b1, "power restored");
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		tick(2);
		srst = 0;
		t_normal();
		t_flush();
		t_readout();
		t_luma();
		t_standby();
		wrap_up();
	end
endmodule // ccd_exposure_mode_control_bench
